//--- common/tcw_regs.vh
// constants for the eight-channel capture / waveform block
// assumes a 16-bit base timer and a simple word-wide register port
`ifndef TCW_REGS_VH
`define TCW_REGS_VH
// register offsets (word index on the plain port)
`define TCW_ADDR_W 5
`define TCW_CH_EN 5'h00
`define TCW_FN_SEL 5'h01
`define TCW_IRQ_CAP 5'h02
`define TCW_IRQ_CMP 5'h03
`define TCW_DIV6 5'h04
`define TCW_DIV7 5'h05
`define TCW_CAPCTL_BASE 5'h08
`define TCW_WAVCTL_BASE 5'h10
`define TCW_CMP_BASE 5'h18
`define TCW_CAPVAL_RD 5'h08
// capture control fields
`define CC_EDGE_LO 0
`define CC_EDGE_HI 1
`define CC_FILT_LO 2
`define CC_FILT_HI 3
`define CC_GATE 4
`define CC_GOC 5
`define CC_GSC 6
`define CC_DIV 7
// edge select codes
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
// filter select codes
`define FILT_OFF 2'h0
`define FILT_SYS 2'h1
`define FILT_BASE 2'h2
// waveform control fields
`define WC_KIND_LO 0
`define WC_KIND_HI 2
`define WC_IVL 4
`define WC_RLD 5
`define WC_INV 7
`define KIND_SINGLE 3'h0
`define KIND_INVERT 3'h1
// base reset select codes
`define BRST_FREE 3'h0
`define BRST_CH0 3'h2
// reset values and the filter all-ones pattern
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define ONES3 3'h7
`define ZERO4 4'h0
// capture store sweep ends after all eight words
`define CLR_DONE 4'h8
`endif

//--- hw/tcw_filter.v
// three-sample digital filter for one channel pin
// assumes the input is already synchronised to clk_sys
`timescale 1ns/100ps
`include "tcw_regs.vh"
module tcw_filter
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // sample strobe and raw level
   input wire sample,
   input wire din,
   // filtered level
   output reg dout
);
   reg [2:0] hist_q; // last three samples
   // shift on every sample, pass only a level held three samples
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hist_q <= 3'h0;
         dout <= 1'b0;
      end
      else if (sample)
      begin
         hist_q <= {hist_q[1:0], din};
         if ({hist_q[1:0], din} == `ONES3)
            dout <= 1'b1;
         else if ({hist_q[1:0], din} == 3'h0)
            dout <= 1'b0;
      end
   end
endmodule // tcw_filter

//--- hw/tcw_capmem.v
// eight-word store of captured base timer values
// assumes one writer per cycle; read data registered
`timescale 1ns/100ps
module tcw_capmem
(
   // clock
   input wire clk_sys,
   // write side
   input wire we,
   input wire [2:0] waddr,
   input wire [15:0] wdata,
   // read side
   input wire [2:0] raddr,
   output reg [15:0] rdata
);
   reg [15:0] mem [0:7]; // no reset: contents hold until overwritten
   // write then registered read
   always @(posedge clk_sys)
   begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule // tcw_capmem

//--- hw/tcw_channels.v
// eight capture / waveform channels beside a 16-bit base timer
// assumes base_count and base_tick come from the base timer on clk_sys
// What this block does
// - capture copies base count into capture value
// - edge select rising, falling or both
// - measure only when enabled and function is one
// - enable zero stops measurement or waveform
// - waveform starts when enabled with function zero
// - divider captures once per reload plus one
// - each capture sets capture interrupt flag
// - filter passes level held three samples
// - gating ignores triggers after first capture
// - gate released by compare four/five or soft
// - single-phase high on match, low at wrap
// - initial level sets starting output level
// - polarity flip inverts final output
// - free-running single-phase period 65536 counts
// - channel zero reset period n plus two
// - inverted mode toggles on each match
// - free-running inverted level lasts 65536 counts
// - reset mode inverted level lasts n plus two
// - compare match on an enabled waveform channel sets compare interrupt flag
// - kind 000b selects single-phase output
// - base timer zeroed two ticks after match
`timescale 1ns/100ps
`include "tcw_regs.vh"
module tcw_channels
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // register port
   input wire [4:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // base timer
   input wire [15:0] base_count,
   input wire base_tick,
   input wire [2:0] base_reset_select,
   // channel pins
   input wire [7:0] channel_pin_in,
   output reg [7:0] channel_pin_out,
   output reg [7:0] channel_pin_oe,
   // base timer reset request on channel 0 match
   output reg base_reset_req
);
   // software registers
   reg [7:0] channel_enable_reg_q; // one bit per channel
   reg [7:0] function_select_reg_q; // 1 measure, 0 waveform
   reg [7:0] capture_irq_flag_q; // sticky capture flags
   reg [7:0] compare_irq_flag_q; // sticky compare flags
   reg [7:0] trigger_divider_reload_q [6:7]; // divider reloads
   reg [7:0] capture_control_q [0:7]; // per-channel capture setup
   reg [7:0] waveform_control_q [0:7]; // per-channel waveform setup
   reg [15:0] compare_value_reg_q [0:7]; // compare values
   // channel state
   reg [7:0] wave_q; // pre-inversion waveform level
   reg [7:0] filt_prev_q; // previous filtered level
   reg [7:0] div_cnt_q [6:7]; // divider down counters
   reg [1:0] gated_q; // gate closed for ch 6, 7
   reg [7:0] en_prev_q; // enable one cycle ago
   reg [1:0] rst_dly_q; // delay of channel 0 match
   reg rd_cap_q; // read was capture memory
   reg [15:0] rd_reg_q; // other read data
   // pin synchroniser, two stages
   reg [7:0] pin_s1_q;
   reg [7:0] pin_s2_q;
   wire [7:0] filt_lvl; // filtered level per channel
   wire [7:0] trig; // edge per channel
   wire [7:0] accept; // capture taken
   wire [7:0] match; // compare equal on a tick
   wire [7:0] in_raw; // level fed to filter
   wire [7:0] samp; // filter sample strobe
   wire [15:0] mem_rdata;
   reg cap_we;
   reg [2:0] cap_ch;
   integer k;
   reg [3:0] clr_q; // zero sweep position after reset
   wire sweep; // capture store still being cleared
   // synchronise channel pins before use
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= `ZERO8;
         pin_s2_q <= `ZERO8;
      end
      else
      begin
         pin_s1_q <= channel_pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : ch
         wire [1:0] fsel;
         wire [1:0] esel;
         wire fdout; // three-sample filter result
         assign fsel = capture_control_q[g][`CC_FILT_HI:`CC_FILT_LO];
         assign esel = capture_control_q[g][`CC_EDGE_HI:`CC_EDGE_LO];
         // sample every sys clock or every base tick
         assign samp[g] = (fsel == `FILT_SYS) | ((fsel == `FILT_BASE) & base_tick);
         assign in_raw[g] = pin_s2_q[g];
         tcw_filter u_filt
         (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .sample(samp[g]),
            .din(in_raw[g]),
            .dout(fdout)
         );
         // filter bypass when off; filtered level otherwise
         assign filt_lvl[g] = (fsel == `FILT_OFF) ? pin_s2_q[g] : fdout;
         // edge selection
         assign trig[g] = (esel == `EDGE_RISE) ? (filt_lvl[g] & ~filt_prev_q[g]) :
            (esel == `EDGE_FALL) ? (~filt_lvl[g] & filt_prev_q[g]) :
            (esel == `EDGE_BOTH) ? (filt_lvl[g] ^ filt_prev_q[g]) : 1'b0;
         // match only counted on a base tick, whatever the channel function
         assign match[g] = base_tick & (base_count == compare_value_reg_q[g]);
      end
   endgenerate
   // accept rule: enabled, measuring, gate open, divider expired
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : acc
         if (g >= 6)
         begin : dv
            wire use_div;
            wire gate_ok;
            assign use_div = capture_control_q[g][`CC_DIV];
            assign gate_ok = ~(capture_control_q[g][`CC_GATE] & gated_q[g-6]);
            assign accept[g] = trig[g] & channel_enable_reg_q[g] & function_select_reg_q[g] & gate_ok &
               (~use_div | (div_cnt_q[g] == `ZERO8));
         end
         else
         begin : nd
            assign accept[g] = trig[g] & channel_enable_reg_q[g] & function_select_reg_q[g];
         end
      end
   endgenerate
   // pick lowest capturing channel for the memory write port
   always @*
   begin
      cap_we = 1'b0;
      cap_ch = 3'h0;
      for (k = 7; k >= 0; k = k - 1)
      begin
         if (accept[k])
         begin
            cap_we = 1'b1;
            cap_ch = k[2:0];
         end
      end
   end
   // zeros swept through the store once after reset, so a channel never captured reads 0
   // captures in those eight cycles would be lost, but every channel is disabled then
   assign sweep = (clr_q != `CLR_DONE);
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         clr_q <= `ZERO4;
      else if (sweep)
         clr_q <= clr_q + 4'h1;
   end
   // capture store; only one channel captures per cycle, others lose that edge
   tcw_capmem u_mem
   (
      .clk_sys(clk_sys),
      .we(cap_we | sweep),
      .waddr(sweep ? clr_q[2:0] : cap_ch),
      .wdata(sweep ? `ZERO16 : base_count),
      .raddr(reg_addr[2:0]),
      .rdata(mem_rdata)
   );
   // register writes and channel sequencing
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         channel_enable_reg_q <= `ZERO8;
         function_select_reg_q <= `ZERO8;
         capture_irq_flag_q <= `ZERO8;
         compare_irq_flag_q <= `ZERO8;
         filt_prev_q <= `ZERO8;
         en_prev_q <= `ZERO8;
         wave_q <= `ZERO8;
         gated_q <= 2'h0;
         trigger_divider_reload_q[6] <= `ZERO8;
         trigger_divider_reload_q[7] <= `ZERO8;
         div_cnt_q[6] <= `ZERO8;
         div_cnt_q[7] <= `ZERO8;
         for (k = 0; k < 8; k = k + 1)
         begin
            capture_control_q[k] <= `ZERO8;
            waveform_control_q[k] <= `ZERO8;
            compare_value_reg_q[k] <= `ZERO16;
         end
      end
      else
      begin
         filt_prev_q <= filt_lvl;
         en_prev_q <= channel_enable_reg_q;
         // software writes; flags cleared by writing ones
         if (reg_wr)
         begin
            case (reg_addr)
               `TCW_CH_EN: channel_enable_reg_q <= reg_wdata[7:0];
               `TCW_FN_SEL: function_select_reg_q <= reg_wdata[7:0];
               `TCW_DIV6: trigger_divider_reload_q[6] <= reg_wdata[7:0];
               `TCW_DIV7: trigger_divider_reload_q[7] <= reg_wdata[7:0];
               default:
               begin
                  if (reg_addr[4:3] == 2'h1)
                     capture_control_q[reg_addr[2:0]] <= reg_wdata[7:0];
                  else if (reg_addr[4:3] == 2'h2)
                     waveform_control_q[reg_addr[2:0]] <= reg_wdata[7:0];
                  else if (reg_addr[4:3] == 2'h3)
                     compare_value_reg_q[reg_addr[2:0]] <= reg_wdata;
               end
            endcase
         end
         // flags: a new event wins over a clear in the same cycle
         capture_irq_flag_q <= (capture_irq_flag_q &
            ~((reg_wr && reg_addr == `TCW_IRQ_CAP) ? reg_wdata[7:0] : `ZERO8)) | accept;
         compare_irq_flag_q <= (compare_irq_flag_q &
            ~((reg_wr && reg_addr == `TCW_IRQ_CMP) ? reg_wdata[7:0] : `ZERO8)) |
            (match & channel_enable_reg_q & ~function_select_reg_q);
         // divider and gate on channels 6 and 7
         for (k = 6; k < 8; k = k + 1)
         begin
            if (!channel_enable_reg_q[k])
            begin
               div_cnt_q[k] <= trigger_divider_reload_q[k];
               gated_q[k-6] <= 1'b0;
            end
            else
            begin
               if (!capture_control_q[k][`CC_DIV])
                  div_cnt_q[k] <= trigger_divider_reload_q[k]; // idle divider preloads, first round is full
               else if (trig[k] && function_select_reg_q[k] &&
                  !(capture_control_q[k][`CC_GATE] && gated_q[k-6]))
               begin
                  if (div_cnt_q[k] == `ZERO8 || !capture_control_q[k][`CC_DIV])
                     div_cnt_q[k] <= trigger_divider_reload_q[k];
                  else
                     div_cnt_q[k] <= div_cnt_q[k] - 8'h01;
               end
               if (accept[k] && capture_control_q[k][`CC_GATE])
                  gated_q[k-6] <= 1'b1;
               else if (capture_control_q[k][`CC_GOC] &&
                  (match[k-2] || capture_control_q[k][`CC_GSC]))
                  gated_q[k-6] <= 1'b0;
            end
         end
         // waveform sequencing per channel
         for (k = 0; k < 8; k = k + 1)
         begin
            if (!channel_enable_reg_q[k] || function_select_reg_q[k])
               wave_q[k] <= waveform_control_q[k][`WC_IVL];
            else if (!en_prev_q[k])
               wave_q[k] <= waveform_control_q[k][`WC_IVL];
            else if (waveform_control_q[k][`WC_KIND_HI:`WC_KIND_LO] == `KIND_SINGLE)
            begin
               // match high, wrap to zero low; periods follow base timer
               if (match[k])
                  wave_q[k] <= 1'b1;
               else if (base_tick && base_count == `ZERO16)
                  wave_q[k] <= 1'b0;
            end
            else if (waveform_control_q[k][`WC_KIND_HI:`WC_KIND_LO] == `KIND_INVERT)
            begin
               if (match[k])
                  wave_q[k] <= ~wave_q[k];
            end
         end
      end
   end
   // request on the first tick after a channel 0 match; the base timer clears on its
   // next count, so zero shows two ticks after the match
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_dly_q <= 2'h0;
         base_reset_req <= 1'b0;
      end
      else
      begin
         base_reset_req <= 1'b0;
         if (base_reset_select == `BRST_CH0 && channel_enable_reg_q[0] && !function_select_reg_q[0])
         begin
            if (match[0])
               rst_dly_q <= 2'h1;
            else if (base_tick && rst_dly_q == 2'h1)
            begin
               rst_dly_q <= 2'h0;
               base_reset_req <= 1'b1;
            end
         end
         else
            rst_dly_q <= 2'h0;
      end
   end
   // pin drive: polarity flip is the last stage
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         channel_pin_out <= `ZERO8;
         channel_pin_oe <= `ZERO8;
      end
      else
      begin
         for (k = 0; k < 8; k = k + 1)
         begin
            channel_pin_out[k] <= wave_q[k] ^ waveform_control_q[k][`WC_INV];
            channel_pin_oe[k] <= channel_enable_reg_q[k] & ~function_select_reg_q[k];
         end
      end
   end
   // register read, data one cycle after the strobe
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_cap_q <= 1'b0;
         rd_reg_q <= `ZERO16;
      end
      else
      begin
         rd_cap_q <= reg_rd && (reg_addr[4:3] == 2'h1);
         rd_reg_q <= `ZERO16;
         if (reg_rd)
         begin
            case (reg_addr)
               `TCW_CH_EN: rd_reg_q <= {8'h00, channel_enable_reg_q};
               `TCW_FN_SEL: rd_reg_q <= {8'h00, function_select_reg_q};
               `TCW_IRQ_CAP: rd_reg_q <= {8'h00, capture_irq_flag_q};
               `TCW_IRQ_CMP: rd_reg_q <= {8'h00, compare_irq_flag_q};
               `TCW_DIV6: rd_reg_q <= {8'h00, trigger_divider_reload_q[6]};
               `TCW_DIV7: rd_reg_q <= {8'h00, trigger_divider_reload_q[7]};
               default:
               begin
                  if (reg_addr[4:3] == 2'h2)
                     rd_reg_q <= {8'h00, waveform_control_q[reg_addr[2:0]]};
                  else if (reg_addr[4:3] == 2'h3)
                     rd_reg_q <= compare_value_reg_q[reg_addr[2:0]];
               end
            endcase
         end
      end
   end
   // final read mux kept combinational into a flop would add a cycle, so select here
   always @*
   begin
      reg_rdata = rd_cap_q ? mem_rdata : rd_reg_q;
   end
endmodule // tcw_channels

//--- test/tcw_channels_properties.sv
// port-level assertions for tcw_channels
// assumes one clock, the plain register port, and sees ports only
`timescale 1ns/100ps
`include "tcw_regs.vh"
module tcw_channels_properties
(
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // register port
   input wire [4:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // base timer
   input wire base_tick,
   input wire [2:0] base_reset_select,
   // outputs
   input wire [7:0] channel_pin_out,
   input wire [7:0] channel_pin_oe,
   input wire base_reset_req
);
   reg [7:0] en_q; // shadow enables
   reg [7:0] fs_q; // shadow function select
   reg [1:0] quiet_q; // edges since an enable or select write, saturating
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // shadows predict pin drive from bus traffic alone
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_q <= 8'h00;
         fs_q <= 8'h00;
         quiet_q <= 2'h0;
      end
      else if (reg_wr && (reg_addr == `TCW_CH_EN || reg_addr == `TCW_FN_SEL))
      begin
         if (reg_addr == `TCW_CH_EN)
            en_q <= reg_wdata[7:0];
         else
            fs_q <= reg_wdata[7:0];
         quiet_q <= 2'h0;
      end
      else if (quiet_q != 2'h3)
         quiet_q <= quiet_q + 2'h1;
   end
   property p_oe_follow;
      quiet_q == 2'h3 |-> channel_pin_oe == (en_q & ~fs_q);
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("pin drive off");
   property p_en_read;
      $past(reg_rd) && $past(reg_addr) == `TCW_CH_EN |-> reg_rdata[7:0] == en_q;
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable readback off");
   property p_fs_read;
      $past(reg_rd) && $past(reg_addr) == `TCW_FN_SEL |-> reg_rdata[7:0] == fs_q;
   endproperty
   a_fs_read: assert property (p_fs_read) else $error("select readback off");
   property p_unmapped;
      $past(reg_rd) && $past(reg_addr) == 5'h06 |-> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_req_mode;
      base_reset_req |-> base_reset_select == `BRST_CH0;
   endproperty
   a_req_mode: assert property (p_req_mode) else $error("clear request in wrong mode");
   property p_req_pulse;
      base_reset_req |=> !base_reset_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("clear request too long");
   property p_req_tick;
      base_reset_req |-> $past(base_tick);
   endproperty
   a_req_tick: assert property (p_req_tick) else $error("clear request off tick");
   // with drive and config steady, the pin moves only two edges after a tick
   property p_out_tick;
      channel_pin_out != $past(channel_pin_out) && $stable(channel_pin_oe)
         && $past(channel_pin_oe) == $past(channel_pin_oe, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
         |-> $past(base_tick, 2);
   endproperty
   a_out_tick: assert property (p_out_tick) else $error("pin moved without tick");
endmodule // tcw_channels_properties
bind tcw_channels tcw_channels_properties u_tcw_channels_properties (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .base_tick(base_tick), .base_reset_select(base_reset_select), .channel_pin_out(channel_pin_out),
   .channel_pin_oe(channel_pin_oe), .base_reset_req(base_reset_req));

//--- test/tcw_pin_source.sv
// far-side signal sources on the eight channel pins
// assumes the bench sets levels and spike masks between clock edges
`timescale 1ns/100ps
module tcw_pin_source
(
   // requested levels and short spikes
   input wire [7:0] level,
   input wire [7:0] spike,
   // pins as seen by the block
   output wire [7:0] pin
);
   // skew keeps edges clear of the clock, so sync flops see clean samples
   assign #7 pin = level ^ spike;
endmodule // tcw_pin_source

//--- test/tcw_channels_test.sv
// self-checking bench for the capture / waveform channels
// assumes the bench plays base timer and software
`timescale 1ns/100ps
`include "tcw_regs.vh"
module tcw_channels_test;
   logic clk_sys, rst_n, reg_wr, reg_rd, base_tick, ph, pend, run; // bench drives
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, base_count, a, e, c3;
   logic [2:0] base_reset_select, ch;
   logic [7:0] pin_level, pin_spike; // source model controls
   wire [15:0] reg_rdata;
   wire [7:0] channel_pin_in, channel_pin_out, channel_pin_oe;
   wire base_reset_req;
   integer num_errors, total_checks, seed, i, k, n, m, t, h;
   tcw_channels u_tcw_channels (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .base_count(base_count), .base_tick(base_tick),
      .base_reset_select(base_reset_select), .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
      .channel_pin_oe(channel_pin_oe), .base_reset_req(base_reset_req));
   tcw_pin_source u_tcw_pin_source (.level(pin_level), .spike(pin_spike), .pin(channel_pin_in));
   // capture expected after one pin edge
   function [15:0] exp_cap(input [1:0] sel, input rising, input [15:0] prev, input [15:0] now);
      exp_cap = (sel == `EDGE_BOTH || (sel == `EDGE_RISE) == rising) ? now : prev;
   endfunction
   // high ticks over a window of two base periods (tt ticks)
   function [15:0] exp_high(input inverted, input flip, input [15:0] tt, input [15:0] mm);
      if (inverted)
         exp_high = tt >> 1;
      else
         exp_high = flip ? mm << 1 : tt - (mm << 1);
   endfunction
   task finish_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // write, with a gap cycle so strobes never get two assignments at once
   task wr(input [4:0] ad, input [15:0] d);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // read; data stands only in the following cycle
   task rd(input [4:0] ad, input [15:0] exp);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clk_sys);
   endtask
   // move one pin with the count frozen, then let sync and filter settle
   task edge_to(input [2:0] c, input v, input [15:0] cnt);
      base_count <= cnt;
      pin_level[c] <= v;
      repeat (12) @(posedge clk_sys);
   endtask
   // ticks and high ticks of pin 1 between the first and third clear request
   task measure;
      k = 0;
      t = 0;
      h = 0;
      while (k < 3 && t < 2000)
      begin
         @(posedge clk_sys);
         #1;
         if (base_reset_req === 1'b1)
            k = k + 1;
         if (k > 0 && k < 3 && base_tick === 1'b1)
         begin
            t = t + 1;
            h = h + channel_pin_out[1];
         end
      end
      @(posedge clk_sys);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // base timer model: a tick every other cycle, zero at the first count after a request
   always @(posedge clk_sys)
   begin
      if (run)
      begin
         ph <= ~ph;
         base_tick <= ph;
         if (ph)
         begin
            base_count <= (pend || base_reset_req) ? 16'h0000 : base_count + 16'h0001;
            pend <= 1'b0;
         end
         else if (base_reset_req)
            pend <= 1'b1;
      end
   end
   // watchdog well beyond the fourteen hundred or so cycles the run needs at most
   initial
   begin
      #(40 * 50000);
      num_errors = num_errors + 1;
      finish_test;
   end
   initial
   begin
      seed = 74190;
      num_errors = 0;
      total_checks = 0;
      {rst_n, reg_wr, reg_rd, base_tick, ph, pend, run} = 7'h00;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      base_count = 16'h0000;
      base_reset_select = `BRST_FREE;
      pin_level = 8'h00;
      pin_spike = 8'h00;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rd(`TCW_CH_EN, 16'h0000);
      rd(`TCW_CAPVAL_RD, 16'h0000);
      rd(5'h06, 16'h0000);
      // edge codes on channels 3 to 5, base count set first by software
      for (i = 0; i < 3; i = i + 1)
         wr(`TCW_CAPCTL_BASE + 5'd3 + i[4:0], {14'h0000, i[1:0]});
      wr(`TCW_FN_SEL, 16'h00f8);
      rd(`TCW_FN_SEL, 16'h00f8);
      wr(`TCW_CH_EN, 16'h00ff);
      for (i = 0; i < 3; i = i + 1)
      begin
         ch = 3'd3 + i[2:0];
         a = 16'($random(seed));
         edge_to(ch, 1'b1, a);
         e = exp_cap(i[1:0], 1'b1, 16'h0000, a);
         rd(`TCW_CAPVAL_RD + {2'b00, ch}, e);
         edge_to(ch, 1'b0, ~a);
         e = exp_cap(i[1:0], 1'b0, e, ~a);
         rd(`TCW_CAPVAL_RD + {2'b00, ch}, e);
         if (i == 0)
            c3 = e;
      end
      rd(`TCW_IRQ_CAP, 16'h0038);
      wr(`TCW_IRQ_CAP, 16'h00ff);
      rd(`TCW_IRQ_CAP, 16'h0000);
      // disabled channel ignores its pin; filter swallows a two-cycle spike
      wr(`TCW_CH_EN, 16'h00f7);
      edge_to(3'd3, 1'b1, 16'h1234);
      rd(`TCW_CAPVAL_RD + 5'd3, c3);
      edge_to(3'd3, 1'b0, 16'h1235);
      wr(`TCW_CAPCTL_BASE + 5'd3, 16'h0004);
      wr(`TCW_CH_EN, 16'h00ff);
      pin_spike[3] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pin_spike[3] <= 1'b0;
      edge_to(3'd3, 1'b0, 16'h2222);
      rd(`TCW_CAPVAL_RD + 5'd3, c3);
      a = 16'($random(seed));
      edge_to(3'd3, 1'b1, a);
      rd(`TCW_CAPVAL_RD + 5'd3, a);
      // divider on channel 6: only trigger reload+1 lands
      n = 1 + {$random(seed)} % 3;
      wr(`TCW_DIV6, n[15:0]);
      wr(`TCW_CAPCTL_BASE + 5'd6, 16'h0080);
      for (i = 0; i <= n; i = i + 1)
      begin
         a = 16'($random(seed));
         edge_to(3'd6, 1'b1, a);
         edge_to(3'd6, 1'b0, ~a);
         rd(`TCW_CAPVAL_RD + 5'd6, (i == n) ? a : 16'h0000);
      end
      // gating on channel 7: deaf after one capture until a soft clear
      wr(`TCW_CAPCTL_BASE + 5'd7, 16'h0030);
      edge_to(3'd7, 1'b1, 16'h0a0a);
      edge_to(3'd7, 1'b0, 16'h0a0b);
      edge_to(3'd7, 1'b1, 16'h0b0b);
      rd(`TCW_CAPVAL_RD + 5'd7, 16'h0a0a);
      wr(`TCW_CAPCTL_BASE + 5'd7, 16'h0070);
      wr(`TCW_CAPCTL_BASE + 5'd7, 16'h0030);
      edge_to(3'd7, 1'b0, 16'h0c0c);
      edge_to(3'd7, 1'b1, 16'h0d0d);
      rd(`TCW_CAPVAL_RD + 5'd7, 16'h0d0d);
      // channel 1 waveforms, base timer cleared by channel 0 match
      base_reset_select <= `BRST_CH0;
      base_count <= 16'h0000;
      n = 8 + {$random(seed)} % 8;
      m = 1 + {$random(seed)} % n;
      wr(`TCW_CMP_BASE, n[15:0]);
      wr(`TCW_WAVCTL_BASE, 16'h0000);
      wr(`TCW_CMP_BASE + 5'd1, m[15:0]);
      wr(`TCW_CMP_BASE + 5'd2, 16'hffff);
      wr(`TCW_CH_EN, 16'h0003);
      run <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`TCW_WAVCTL_BASE + 5'd1, {8'h00, i[1], 6'h00, i[0]});
         repeat (8 * n) @(posedge clk_sys);
         measure;
         chk(h[15:0], exp_high(i[0], i[1], t[15:0], m[15:0]));
         rd(`TCW_IRQ_CMP, 16'h0003);
         wr(`TCW_IRQ_CMP, 16'h00ff);
      end
      // starting level on channel 2, base stopped off zero
      run <= 1'b0;
      @(posedge clk_sys);
      base_tick <= 1'b0;
      base_count <= 16'h0005;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`TCW_WAVCTL_BASE + 5'd2, {8'h00, i[1], 2'h0, i[0], 4'h0});
         wr(`TCW_CH_EN, 16'h0007);
         repeat (3) @(posedge clk_sys);
         #1 chk({15'h0000, channel_pin_out[2]}, {15'h0000, i[0] ^ i[1]});
         wr(`TCW_CH_EN, 16'h0003);
      end
      finish_test;
   end
endmodule // tcw_channels_test
